/* verilog/ccs_pkg.sv */
// Purpose: shared constants and carrier types of the core status registers
// Assumes: 32-bit register words, 12-bit register addresses
// Notes: every address, field position and reset value lives here, except the extension status reset (EXT_CTX_RESET)
package ccs_pkg;

    // register addresses
    localparam logic [11:0] ADDR_TABLE_JUMP_BASE = 12'h017;
    localparam logic [11:0] ADDR_STATUS_WORD = 12'h300;
    localparam logic [11:0] ADDR_CYCLE_LO = 12'hC00;
    localparam logic [11:0] ADDR_TIME_LO = 12'hC01;
    localparam logic [11:0] ADDR_RETIRED_LO = 12'hC02;
    localparam logic [11:0] ADDR_PERF_FIRST_LO = 12'hC03;
    localparam logic [11:0] ADDR_PERF_LAST_LO = 12'hC1F;
    localparam logic [11:0] ADDR_CYCLE_HI = 12'hC80;
    localparam logic [11:0] ADDR_TIME_HI = 12'hC81;
    localparam logic [11:0] ADDR_RETIRED_HI = 12'hC82;
    localparam logic [11:0] ADDR_PERF_FIRST_HI = 12'hC83;
    localparam logic [11:0] ADDR_PERF_LAST_HI = 12'hC9F;

    // counter window decode: top address bits of low and high halves
    localparam logic [6:0] CNT_LO_PAGE = 7'h60;
    localparam logic [6:0] CNT_HI_PAGE = 7'h64;
    localparam logic [1:0] READ_ONLY_SPACE = 2'h3;

    // counter slots inside a window
    localparam int CNT_SLOTS = 32;
    localparam int SLOT_CYCLE = 0;
    localparam int SLOT_TIME = 1;
    localparam int SLOT_RETIRED = 2;
    localparam int SLOT_PERF_FIRST = 3;
    localparam int PERF_COUNT_MAX = 29;

    // machine status field positions
    localparam int DIRTY_SUM_BIT = 31;
    localparam int EXT_CTX_LSB = 15;
    localparam int FLOAT_CTX_LSB = 13;
    localparam int PREV_PRIV_LSB = 11;
    localparam int VEC_CTX_LSB = 9;
    localparam int PREV_IE_BIT = 7;
    localparam int MIE_BIT = 3;

    // table jump base layout
    localparam int TJB_BASE_LSB = 6;

    // values after reset and fixed values
    localparam logic [31:0] TJB_RESET = 32'h0000_0000;
    localparam logic [1:0] PREV_PRIV_MACHINE = 2'h3;
    localparam logic [1:0] CTX_OFF = 2'h0;
    localparam logic [1:0] CTX_DIRTY = 2'h3;
    localparam logic MIE_RESET = 1'h0;
    localparam logic PREV_IE_RESET = 1'h0;
    localparam logic [63:0] CNT_RESET = 64'h0;
    localparam int RESET_SYNC_STAGES = 2;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ccs_req_type;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] rdata;
    } ccs_rsp_type;

    typedef struct packed {
        logic mie;
        logic prev_ie;
        logic [1:0] ext_ctx;
        logic [1:0] float_ctx;
        logic [1:0] vec_ctx;
    } ccs_status_type;

endpackage

/* verilog/ccs_cnt64.sv */
// Purpose: one 64-bit event counter
// Assumes: active-low reset copy from the top, asserted asynchronously and released in step with the clock
// Notes: wraps at the top of its range
`timescale 1ns/1ps
module ccs_cnt64 (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    output logic [63:0] value_o
);
    logic [63:0] count_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= ccs_pkg::CNT_RESET;
        end else if (inc_i) begin
            count_q <= count_q + 64'h1;
        end
    end

    assign value_o = count_q;
endmodule

/* verilog/ccs_mstatus.sv */
// Purpose: machine status word with interrupt-enable stacking
// Assumes: trap and return strobes are one-cycle pulses
// Notes: on the enable bits trap beats return beats software write in the same cycle; float and vector status take the write
`timescale 1ns/1ps
module ccs_status_word #(
    parameter bit EXT_IF = 1'b0,
    parameter logic [1:0] EXT_CTX_RESET = 2'h0
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic write_i,
    input wire logic [31:0] wdata_i,
    input wire logic trap_i,
    input wire logic mret_i,
    output ccs_pkg::ccs_status_type status_o,
    output logic [31:0] word_o
);
    logic mie_q;
    logic prev_ie_q;
    logic [1:0] ext_ctx_val;
    logic [1:0] float_ctx_q;
    logic [1:0] vec_ctx_q;

    // interrupt enable and its stacked copy
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mie_q <= ccs_pkg::MIE_RESET;
            prev_ie_q <= ccs_pkg::PREV_IE_RESET;
        end else if (trap_i) begin
            prev_ie_q <= mie_q;
            mie_q <= 1'h0;
        end else if (mret_i) begin
            mie_q <= prev_ie_q;
            prev_ie_q <= 1'h1;
        end else if (write_i) begin
            mie_q <= wdata_i[ccs_pkg::MIE_BIT];
            prev_ie_q <= wdata_i[ccs_pkg::PREV_IE_BIT];
        end
    end

    // extension status never takes writes: it holds EXT_CTX_RESET with the extension interface, off without
    assign ext_ctx_val = EXT_IF ? EXT_CTX_RESET : ccs_pkg::CTX_OFF;

    // float and vector status, live only with the extension interface
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            float_ctx_q <= ccs_pkg::CTX_OFF;
            vec_ctx_q <= ccs_pkg::CTX_OFF;
        end else if (write_i && EXT_IF) begin
            float_ctx_q <= wdata_i[ccs_pkg::FLOAT_CTX_LSB +: 2];
            vec_ctx_q <= wdata_i[ccs_pkg::VEC_CTX_LSB +: 2];
        end
    end

    // all bits not set below read as zero
    always_comb begin
        word_o = 32'h0000_0000;
        word_o[ccs_pkg::DIRTY_SUM_BIT] =
            (float_ctx_q == ccs_pkg::CTX_DIRTY) ||
            (ext_ctx_val == ccs_pkg::CTX_DIRTY) ||
            (vec_ctx_q == ccs_pkg::CTX_DIRTY);
        word_o[ccs_pkg::EXT_CTX_LSB +: 2] = ext_ctx_val;
        word_o[ccs_pkg::FLOAT_CTX_LSB +: 2] = float_ctx_q;
        word_o[ccs_pkg::PREV_PRIV_LSB +: 2] =
            ccs_pkg::PREV_PRIV_MACHINE;
        word_o[ccs_pkg::VEC_CTX_LSB +: 2] = vec_ctx_q;
        word_o[ccs_pkg::PREV_IE_BIT] = prev_ie_q;
        word_o[ccs_pkg::MIE_BIT] = mie_q;
    end

    assign status_o = '{mie: mie_q, prev_ie: prev_ie_q,
        ext_ctx: ext_ctx_val, float_ctx: float_ctx_q, vec_ctx: vec_ctx_q};
endmodule

/* verilog/ccs_csr_bank.sv */
// Purpose: status, table-jump base and user counter register bank
// Assumes: one request per cycle from the pipeline, answered next cycle
// Notes: writes carry the full new word; set/clear forms are resolved
//        by the pipeline before the request arrives
`timescale 1ns/1ps

module ccs_csr_bank #(
    parameter bit EXT_IF = 1'b0,
    parameter logic [1:0] EXT_CTX_RESET = 2'h0,
    parameter int NUM_PERF = 29
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input ccs_pkg::ccs_req_type req_i,
    input wire logic trap_i,
    input wire logic mret_i,
    input wire logic retire_i,
    input wire logic [63:0] time_i,
    input wire logic [28:0] perf_event_i,
    output ccs_pkg::ccs_rsp_type rsp_o,
    output logic irq_enable_o,
    output logic [31:0] table_jump_base_o,
    output logic [1:0] float_context_status_o,
    output logic [1:0] vector_context_status_o
);

    // elaboration check on the counter count
    if (NUM_PERF < 0 || NUM_PERF > ccs_pkg::PERF_COUNT_MAX) begin : g_chk
        $error("NUM_PERF must lie between 0 and 29");
    end

    // ------------------------------------------------------------------
    // reset release through two flip-flops
    logic [ccs_pkg::RESET_SYNC_STAGES-1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[ccs_pkg::RESET_SYNC_STAGES-2:0], 1'h1};
        end
    end

    assign rst_n = rst_sync_q[ccs_pkg::RESET_SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // address decode helpers
    function automatic logic is_counter(input logic [11:0] addr);
        return (addr[11:5] == ccs_pkg::CNT_LO_PAGE) ||
            (addr[11:5] == ccs_pkg::CNT_HI_PAGE);
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == ccs_pkg::ADDR_TABLE_JUMP_BASE) ||
            (addr == ccs_pkg::ADDR_STATUS_WORD) || is_counter(addr);
    endfunction

    // an access is illegal on address alone: unmapped, or a write into
    // the read-only address space; field classes play no part here
    function automatic logic is_illegal(input ccs_pkg::ccs_req_type r);
        return !is_mapped(r.addr) ||
            (r.wr && r.addr[11:10] == ccs_pkg::READ_ONLY_SPACE);
    endfunction

    logic req_any;
    logic req_bad;
    logic wr_ok;

    assign req_any = req_i.rd || req_i.wr;
    assign req_bad = is_illegal(req_i);
    assign wr_ok = req_i.wr && !req_bad;

    // ------------------------------------------------------------------
    // table jump base: upper field stored, mode field fixed at zero
    logic [31:0] tjb_q;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tjb_q <= ccs_pkg::TJB_RESET;
        end else if (wr_ok && req_i.addr == ccs_pkg::ADDR_TABLE_JUMP_BASE) begin
            tjb_q <= {req_i.wdata[31:ccs_pkg::TJB_BASE_LSB],
                {ccs_pkg::TJB_BASE_LSB{1'b0}}};
        end
    end

    // ------------------------------------------------------------------
    // machine status word
    ccs_pkg::ccs_status_type status;
    logic [31:0] status_word;
    logic status_wr;

    assign status_wr = wr_ok && req_i.addr == ccs_pkg::ADDR_STATUS_WORD;

    ccs_status_word #(
        .EXT_IF(EXT_IF),
        .EXT_CTX_RESET(EXT_CTX_RESET)
    ) u_status (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .write_i(status_wr),
        .wdata_i(req_i.wdata),
        .trap_i(trap_i),
        .mret_i(mret_i),
        .status_o(status),
        .word_o(status_word)
    );

    // ------------------------------------------------------------------
    // counters: one 64-bit value per slot of the counter window
    logic [63:0] cnt_all [ccs_pkg::CNT_SLOTS];
    logic [63:0] time_q;

    // time is sampled from the platform timer, not counted here
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            time_q <= ccs_pkg::CNT_RESET;
        end else begin
            time_q <= time_i;
        end
    end

    ccs_cnt64 u_cycle (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .inc_i(1'h1),
        .value_o(cnt_all[ccs_pkg::SLOT_CYCLE])
    );

    ccs_cnt64 u_retired (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .inc_i(retire_i),
        .value_o(cnt_all[ccs_pkg::SLOT_RETIRED])
    );

    assign cnt_all[ccs_pkg::SLOT_TIME] = time_q;

    // performance counters; missing ones read as zero
    for (genvar k = 0; k < ccs_pkg::PERF_COUNT_MAX; k++) begin : g_perf
        if (k < NUM_PERF) begin : g_on
            ccs_cnt64 u_perf (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n),
                .inc_i(perf_event_i[k]),
                .value_o(cnt_all[ccs_pkg::SLOT_PERF_FIRST + k])
            );
        end else begin : g_off
            assign cnt_all[ccs_pkg::SLOT_PERF_FIRST + k] = ccs_pkg::CNT_RESET;
        end
    end

    // ------------------------------------------------------------------
    // read data: both halves of a counter index the same slot by the
    // low five address bits, bit 7 picks the half
    logic [31:0] rdata;
    logic [63:0] cnt_sel;

    assign cnt_sel = cnt_all[req_i.addr[4:0]];

    always_comb begin
        rdata = 32'h0000_0000;
        if (req_i.addr == ccs_pkg::ADDR_TABLE_JUMP_BASE) begin
            rdata = tjb_q;
        end else if (req_i.addr == ccs_pkg::ADDR_STATUS_WORD) begin
            rdata = status_word;
        end else if (is_counter(req_i.addr)) begin
            if (req_i.addr[7]) begin
                rdata = cnt_sel[63:32];
            end else begin
                rdata = cnt_sel[31:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // answer one cycle after the request; illegal reads return zero
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= req_any;
            rsp_o.illegal <= req_any && req_bad;
            rsp_o.rdata <= (req_i.rd && !req_bad) ? rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // registered side outputs for the rest of the core
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_o <= ccs_pkg::MIE_RESET;
            table_jump_base_o <= ccs_pkg::TJB_RESET;
            float_context_status_o <= ccs_pkg::CTX_OFF;
            vector_context_status_o <= ccs_pkg::CTX_OFF;
        end else begin
            irq_enable_o <= status.mie;
            table_jump_base_o <= tjb_q;
            float_context_status_o <= status.float_ctx;
            vector_context_status_o <= status.vec_ctx;
        end
    end

endmodule

/* bench/ccs_csr_bank_chk.sv */
// Purpose: port checks of the status register bank
// Assumes: answer one cycle after request, pin copies one cycle later
// Notes: bound from the bench top
`timescale 1ns/1ps
module ccs_csr_bank_chk #(
    parameter bit EXT_IF = 1'b0,
    parameter logic [1:0] EXT_CTX_RESET = 2'h0,
    parameter int NUM_PERF = 29
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input ccs_pkg::ccs_req_type req_i,
    input wire logic trap_i,
    input wire logic mret_i,
    input ccs_pkg::ccs_rsp_type rsp_o,
    input wire logic irq_enable_o,
    input wire logic [31:0] table_jump_base_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic st_rd;
    logic st_wr;
    logic [31:0] d;
    assign st_rd = req_i.rd && req_i.addr == 12'h300;
    assign st_wr = req_i.wr && req_i.addr == 12'h300;
    assign d = rsp_o.rdata;
    a_ro_write: assert property (
        req_i.wr && req_i.addr[11:10] == 2'h3 |=> rsp_o.illegal && d == 32'h0)
        else $error("counter write not refused");
    a_jump_write: assert property (
        req_i.wr && req_i.addr == 12'h017 |-> ##2
        table_jump_base_o[31:6] == $past(req_i.wdata[31:6], 2))
        else $error("jump base not written");
    a_jump_mode: assert property (table_jump_base_o[5:0] == 6'h00)
        else $error("jump mode not zero");
    a_status_fixed: assert property (
        st_rd |=> (d & 32'h7FFE_0177) == 32'h0 && d[12:11] == 2'h3 &&
        d[16:15] == (EXT_IF ? EXT_CTX_RESET : 2'h0))
        else $error("fixed status bits wrong");
    a_dirty_sum: assert property (
        st_rd |=> d[31] == (d[16:15] == 2'h3 || d[14:13] == 2'h3 ||
        d[10:9] == 2'h3))
        else $error("dirty summary wrong");
    a_trap_clear: assert property (trap_i |-> ##2 !irq_enable_o)
        else $error("trap left enable set");
    a_stack_back: assert property (
        trap_i ##1 (mret_i && !trap_i) |-> ##2
        irq_enable_o == $past(irq_enable_o, 2))
        else $error("return did not restore enable");
    a_enable_write: assert property (
        st_wr && !trap_i && !mret_i |-> ##2
        irq_enable_o == $past(req_i.wdata[3], 2))
        else $error("enable not written");
endmodule

/* bench/ccs_pipe_model.sv */
// Purpose: pipeline-side event source for the register bank
// Assumes: run_i changes just after a rising edge
// Notes: tallies what it issued so counters can be predicted
`timescale 1ns/1ps
module ccs_pipe_model (
    input wire logic sys_clk_i,
    input wire logic run_i,
    output logic retire_o,
    output logic [63:0] time_o,
    output logic [28:0] perf_o
);
    int n_run = 0;
    int n_ret = 0;
    logic tog = 1'h0;
    logic go;
    initial begin
        retire_o = 1'h0;
        time_o = 64'h0000_0001_FFFF_FFF8;
        perf_o = '0;
    end
    always @(posedge sys_clk_i) begin
        go = run_i;
        if (perf_o[0]) n_run++;
        if (retire_o) n_ret++;
        #1;
        tog = ~tog;
        retire_o = go & tog;
        perf_o = {go & tog, {28{go}}};
        if (go) time_o = time_o + 64'h1;
    end
endmodule

/* bench/ccs_csr_bank_tb.sv */
// Purpose: self-checking bench of the status register bank
// Assumes: extension interface on, extension status reset to 1
// Notes: retired and perf counters predicted from the pipeline model's tallies, time from its time output
`timescale 1ns/1ps
module ccs_csr_bank_tb;
    logic sys_clk_i = 1'h0, resetn_i = 1'h0, trap_i = 1'h0, mret_i = 1'h0;
    logic run = 1'h0, retire_i, irq_o;
    logic [63:0] time_i;
    logic [28:0] perf_event_i;
    logic [31:0] tjb, v;
    logic [1:0] fcs, vcs;
    ccs_pkg::ccs_req_type req_i = '0;
    ccs_pkg::ccs_rsp_type rsp_o, rsp_plain;
    int n_mismatch = 0, checks_done = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    ccs_pipe_model u_pipe (.sys_clk_i(sys_clk_i), .run_i(run),
        .retire_o(retire_i), .time_o(time_i), .perf_o(perf_event_i));
    // second copy without the extension interface and without perf counters
    ccs_csr_bank #(.EXT_IF(1'b0), .EXT_CTX_RESET(2'h3), .NUM_PERF(0))
        dut_plain (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .req_i(req_i), .trap_i(trap_i), .mret_i(mret_i),
        .retire_i(retire_i), .time_i(time_i),
        .perf_event_i(perf_event_i), .rsp_o(rsp_plain),
        .irq_enable_o(), .table_jump_base_o(),
        .float_context_status_o(), .vector_context_status_o());
    ccs_csr_bank #(.EXT_IF(1'b1), .EXT_CTX_RESET(2'h1), .NUM_PERF(29)) dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req_i),
        .trap_i(trap_i), .mret_i(mret_i), .retire_i(retire_i),
        .time_i(time_i), .perf_event_i(perf_event_i), .rsp_o(rsp_o),
        .irq_enable_o(irq_o), .table_jump_base_o(tjb),
        .float_context_status_o(fcs), .vector_context_status_o(vcs));
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(logic r, logic w, logic [11:0] a, logic [31:0] d,
                          logic ill);
        req_i = '{rd: r, wr: w, addr: a, wdata: d};
        tick();
        v = rsp_o.rdata;
        check("valid", 32'(rsp_o.valid), 32'h1);
        check("illegal", 32'(rsp_o.illegal), 32'(ill));
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, string what);
        access(1'h1, 1'h0, a, 32'h0, 1'h0);
        check(what, v, e);
    endtask
    // two strobe cycles with the request bus idle
    task automatic pulse(logic t1, logic m1, logic t2, logic m2);
        req_i = '0;
        trap_i = t1;
        mret_i = m1;
        tick();
        trap_i = t2;
        mret_i = m2;
        tick();
        trap_i = 1'h0;
        mret_i = 1'h0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        #1 resetn_i = 1'h1;
        repeat (2) tick();
        rd(12'h017, 32'h0, "jump reset");
        rd(12'h300, 32'h0000_9800, "status reset");
        check("plain reset", rsp_plain.rdata, 32'h0000_1800);
        access(1'h0, 1'h1, 12'h017, 32'hFFFF_FFFF, 1'h0);
        rd(12'h017, 32'hFFFF_FFC0, "jump ones");
        access(1'h1, 1'h1, 12'h017, 32'h1234_567F, 1'h0);
        check("jump old", v, 32'hFFFF_FFC0);
        rd(12'h017, 32'h1234_5640, "jump new");
        access(1'h0, 1'h1, 12'h300, 32'hFFFF_FFFF, 1'h0);
        rd(12'h300, 32'h8000_FE88, "status ones");
        check("plain ones", rsp_plain.rdata, 32'h0000_1888);
        check("float pin", 32'(fcs), 32'h3);
        check("jump pin", tjb, 32'h1234_5640);
        access(1'h0, 1'h1, 12'h300, 32'h0000_0600, 1'h0);
        rd(12'h300, 32'h8000_9E00, "vector dirty");
        check("vector pin", 32'(vcs), 32'h3);
        access(1'h0, 1'h1, 12'h300, 32'h0, 1'h0);
        rd(12'h300, 32'h0000_9800, "status zero");
        // set the enable keeping every other field as read
        access(1'h0, 1'h1, 12'h300, v | 32'h8, 1'h0);
        pulse(1'h0, 1'h0, 1'h0, 1'h0);
        check("enable pin", 32'(irq_o), 32'h1);
        pulse(1'h1, 1'h0, 1'h0, 1'h0);
        check("enable trap", 32'(irq_o), 32'h0);
        rd(12'h300, 32'h0000_9880, "after trap");
        pulse(1'h0, 1'h1, 1'h0, 1'h0);
        rd(12'h300, 32'h0000_9888, "after return");
        pulse(1'h1, 1'h0, 1'h0, 1'h1);
        rd(12'h300, 32'h0000_9888, "trap return");
        pulse(1'h1, 1'h1, 1'h0, 1'h0);
        rd(12'h300, 32'h0000_9880, "trap wins");
        pulse(1'h1, 1'h0, 1'h0, 1'h1);
        rd(12'h300, 32'h0000_9880, "trap return off");
        access(1'h0, 1'h1, 12'hC00, 32'hFFFF_FFFF, 1'h1);
        check("ro data", v, 32'h0);
        access(1'h1, 1'h0, 12'hC20, 32'h0, 1'h1);
        access(1'h1, 1'h0, 12'h123, 32'h0, 1'h1);
        check("unmapped data", v, 32'h0);
        access(1'h1, 1'h0, 12'hC00, 32'h0, 1'h0);
        rd(12'hC00, v + 32'h1, "cycle step");
        req_i = '0;
        run = 1'h1;
        repeat (40) tick();
        run = 1'h0;
        repeat (3) tick();
        rd(12'hC01, time_i[31:0], "time low");
        rd(12'hC81, time_i[63:32], "time high");
        rd(12'hC02, 32'(u_pipe.n_ret), "retired");
        rd(12'hC82, 32'h0, "retired high");
        rd(12'hC03, 32'(u_pipe.n_run), "perf first");
        check("perf absent", rsp_plain.rdata, 32'h0);
        rd(12'hC1F, 32'(u_pipe.n_ret), "perf last");
        rd(12'hC9F, 32'h0, "perf last high");
        final_report();
    end
endmodule
bind ccs_csr_bank ccs_csr_bank_chk #(.EXT_IF(EXT_IF),
    .EXT_CTX_RESET(EXT_CTX_RESET), .NUM_PERF(NUM_PERF))
    u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .trap_i(trap_i), .mret_i(mret_i), .rsp_o(rsp_o),
    .irq_enable_o(irq_enable_o), .table_jump_base_o(table_jump_base_o));
